// File: verilog/synth2_pkg.sv
package synth2_pkg;

  // Bus geometry
  localparam int          APB_AW   = 12;
  localparam int          APB_DW   = 32;
  localparam int          REG_W    = 8;
  localparam int          NUM_REGS = 8;
  localparam int          SLOT_W   = 3;
  localparam int          IDX_W    = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL_A       = 10'h047;
  localparam logic [IDX_W-1:0] IDX_CTRL_B       = 10'h048;
  localparam logic [IDX_W-1:0] IDX_DIV_HIGH     = 10'h049;
  localparam logic [IDX_W-1:0] IDX_DIV_LOW      = 10'h04a;
  localparam logic [IDX_W-1:0] IDX_NUM_TOP      = 10'h04b;
  localparam logic [IDX_W-1:0] IDX_NUM_MID      = 10'h04c;
  localparam logic [IDX_W-1:0] IDX_NUM_BOTTOM   = 10'h04d;
  localparam logic [IDX_W-1:0] IDX_DEN_TOP      = 10'h04e;
  localparam logic [IDX_W-1:0] IDX_STATUS       = 10'h060;

  // Slot numbers inside the register array
  localparam logic [SLOT_W-1:0] SLOT_CTRL_A     = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_CTRL_B     = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_DIV_HIGH   = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_DIV_LOW    = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_NUM_TOP    = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_NUM_MID    = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_NUM_BOTTOM = 3'h6;
  localparam logic [SLOT_W-1:0] SLOT_DEN_TOP    = 3'h7;

  // Field positions
  localparam int          POST_SEL_LSB = 2;
  localparam int          POST_SEL_MSB = 4;
  localparam int          RESYNC_BIT   = 1;
  localparam int          PDN_BIT      = 0;
  localparam int          DOUBLER_BIT  = 4;
  localparam int          CP_MSB       = 3;
  localparam int          DIV_HI_MSB   = 3;
  localparam int          TOP6_MSB     = 5;
  localparam int          STS_ENABLE   = 0;
  localparam int          STS_BUSY     = 1;
  localparam int          STS_DONE     = 2;

  // Reset values and writable-bit masks, by slot
  localparam logic [REG_W-1:0] RST_VALUES [NUM_REGS] =
    '{8'h1e, 8'h18, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [REG_W-1:0] WR_MASKS [NUM_REGS] =
    '{8'h1f, 8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h3f};

  // Decoded ratio limits and reset values of the decoded outputs
  localparam logic [3:0]  POST_MIN_RATIO   = 4'h2;
  localparam logic [3:0]  POST_STEP        = 4'h1;
  localparam logic [11:0] INT_MIN_RATIO    = 12'h001;
  localparam logic [3:0]  POST_RATIO_RST   = 4'h8;
  localparam logic [11:0] INT_RATIO_RST    = 12'h064;
  localparam logic [6:0]  CP_CURRENT_RST   = 7'h1c;

  // Charge pump current in 0.1 mA steps by gain code; unlisted codes give zero
  localparam logic [6:0]  CP_TABLE [16] =
    '{7'h00, 7'h04, 7'h08, 7'h10, 7'h40, 7'h0c, 7'h14, 7'h18,
      7'h1c, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};

  // Calibration timing
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          CAL_TIME_NS      = 10000;
  localparam int          CAL_CYCLES_DFLT  = CAL_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CAL_OFF,
    CAL_RUN,
    CAL_DONE
  } cal_state_t;

endpackage

// File: verilog/synth_cfg_if.sv
`timescale 1ns/100ps
interface synth_cfg_if;
  logic [2:0]  post_sel;
  logic [11:0] int_div;
  logic [3:0]  cp_gain;
  logic [3:0]  post_ratio;
  logic [11:0] int_ratio;
  logic [6:0]  cp_current;

  modport regs   (output post_sel, int_div, cp_gain, input post_ratio, int_ratio, cp_current);
  modport decode (input post_sel, int_div, cp_gain, output post_ratio, int_ratio, cp_current);
endinterface

// File: verilog/synth_cfg_decode.sv
`timescale 1ns/100ps
module synth_cfg_decode
  import synth2_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw fields in, decoded values out
  synth_cfg_if.decode cfg
);

  // Post-divider: codes below two clamp to two, higher codes give code plus one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.post_ratio <= POST_RATIO_RST;
    end else if ({1'b0, cfg.post_sel} < POST_MIN_RATIO) begin
      cfg.post_ratio <= POST_MIN_RATIO;
    end else begin
      cfg.post_ratio <= {1'b0, cfg.post_sel} + POST_STEP;
    end
  end

  // Integer divider: zero and one both mean divide by one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.int_ratio <= INT_RATIO_RST;
    end else if (cfg.int_div <= INT_MIN_RATIO) begin
      cfg.int_ratio <= INT_MIN_RATIO;
    end else begin
      cfg.int_ratio <= cfg.int_div;
    end
  end

  // Charge pump current lookup; the mapping is not monotonic, so a table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.cp_current <= CP_CURRENT_RST;
    end else begin
      cfg.cp_current <= CP_TABLE[cfg.cp_gain];
    end
  end

endmodule

// File: verilog/second_synth_config_regs.sv
// How it works
// - Three-bit post-divider code: zero and one divide by two, others by code plus one.
// - With resync enabled (reset one), a sync event resynchronizes this synthesizer's channels.
// - After hardware reset with power-down clear, enable synthesizer and calibrate automatically.
// - Setting power-down disables the synthesizer and holds calibration in reset.
// - Clearing power-down re-enables the synthesizer and restarts calibration by itself.
// - Doubler bit (reset one) doubles the secondary reference fed to this synthesizer.
// - Four-bit gain code picks charge pump current through a non-monotonic table.
// - Integer divider bits eleven to eight come from the high register's low nibble.
// - Divider low byte resets to 0x64; codes zero and one divide by one.
// - Numerator bits 21..16 from low six bits of top register; all reset zero.
// - Middle numerator register gives bits 15..8, bottom register bits 7..0.
// - Denominator bits 21..16 come from low six bits of its top register.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
module second_synth_config_regs
  import synth2_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic [APB_AW-1:0]   paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [APB_DW-1:0]   pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [APB_DW-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Synchronization event pin
  input  wire logic                sync_event_pin,
  // Channel resynchronization request
  output logic                     channel_resync,
  // Synthesizer power and calibration
  output logic                     synth_enable,
  output logic                     cal_reset,
  output logic                     cal_busy,
  output logic                     cal_done,
  // Reference path
  output logic                     secondary_ref_doubler_enable,
  // Loop settings
  output logic [3:0]               charge_pump_gain,
  output logic [6:0]               charge_pump_current,
  output logic [2:0]               post_divider_select,
  output logic [3:0]               post_divide_ratio,
  output logic                     resync_enable,
  output logic                     synth_power_down,
  // Feedback divider
  output logic [11:0]              integer_feedback_divider,
  output logic [11:0]              integer_divide_ratio,
  output logic [21:0]              fractional_numerator,
  output logic [5:0]               fractional_denominator_top
);

  localparam int CNT_W = (CAL_CYCLES > 1) ? $clog2(CAL_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CAL_CYCLES - 1);

  // Register storage, one byte per slot
  logic [REG_W-1:0]  regs_q [NUM_REGS];

  // Bus decode
  logic [IDX_W-1:0]  word_idx;
  logic              aligned;
  logic              slot_hit;
  logic              status_hit;
  logic              addr_hit;
  logic [IDX_W-1:0]  slot_offset;
  logic [SLOT_W-1:0] slot;
  logic              setup_phase;
  logic              access_phase;
  logic              wr_en;
  logic [APB_DW-1:0] prdata_q;
  logic [APB_DW-1:0] rd_word;
  logic [REG_W-1:0]  status_byte;

  // Calibration sequencer
  cal_state_t        state_q;
  logic [CNT_W-1:0]  cnt_q;

  // Sync pin synchronizer and edge detect
  logic              sync_meta_q;
  logic              sync_stable_q;
  logic              sync_prev_q;
  logic              channel_resync_q;

  // Decoder link
  synth_cfg_if       cfg_bus ();

  // Address decode; low address bits must be zero for a hit
  assign word_idx    = paddr[APB_AW-1:2];
  assign aligned     = (paddr[1:0] == 2'h0);
  assign slot_offset = word_idx - IDX_CTRL_A;
  assign slot        = slot_offset[SLOT_W-1:0];
  assign slot_hit    = aligned && (word_idx >= IDX_CTRL_A) && (word_idx <= IDX_DEN_TOP);
  assign status_hit  = aligned && (word_idx == IDX_STATUS);
  assign addr_hit    = slot_hit || status_hit;

  // Phases of an APB transfer
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;

  // Only the low byte lane carries register data; other lanes are ignored
  assign wr_en = access_phase && pwrite && slot_hit && pstrb[0];

  // Register writes; reserved bits are masked so they stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= RST_VALUES[i];
      end
    end else if (wr_en) begin
      regs_q[slot] <= pwdata[REG_W-1:0] & WR_MASKS[slot];
    end
  end

  // Status byte shows the sequencer's own state
  always_comb begin
    status_byte             = '0;
    status_byte[STS_ENABLE] = synth_enable;
    status_byte[STS_BUSY]   = cal_busy;
    status_byte[STS_DONE]   = cal_done;
  end

  // Read mux; bits above the byte read as zero
  always_comb begin
    rd_word = '0;
    if (slot_hit) begin
      rd_word[REG_W-1:0] = regs_q[slot];
    end else if (status_hit) begin
      rd_word[REG_W-1:0] = status_byte;
    end
  end

  // Read data is captured in the setup cycle so prdata comes from a flop
  // and the access phase can complete with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  // APB answer: always ready, error on any unmapped or unaligned address
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access_phase && !addr_hit;

  // Calibration sequencer. Reset lands in CAL_RUN because power-down
  // resets to zero, so calibration starts on its own after reset.
  // A power-down write must persist at least one cycle to be seen, which
  // any APB write does, so a set-then-clear pair always restarts calibration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CAL_RUN;
    end else begin
      case (state_q)
        CAL_OFF: begin
          if (!synth_power_down) begin
            state_q <= CAL_RUN;
          end
        end
        CAL_RUN: begin
          if (synth_power_down) begin
            state_q <= CAL_OFF;
          end else if (cnt_q == CNT_LAST) begin
            state_q <= CAL_DONE;
          end
        end
        CAL_DONE: begin
          if (synth_power_down) begin
            state_q <= CAL_OFF;
          end
        end
        default: begin
          state_q <= CAL_OFF;
        end
      endcase
    end
  end

  // Calibration timer; cleared whenever calibration is not running so a
  // restart always gets the full interval.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (state_q == CAL_RUN && !synth_power_down && cnt_q != CNT_LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (state_q != CAL_RUN) begin
      cnt_q <= '0;
    end
  end

  // Power and calibration outputs follow the sequencer state
  assign synth_enable = (state_q != CAL_OFF);
  assign cal_reset    = (state_q == CAL_OFF);
  assign cal_busy     = (state_q == CAL_RUN);
  assign cal_done     = (state_q == CAL_DONE);

  // Sync pin crosses into pclk through two flops before anything reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta_q   <= 1'b0;
      sync_stable_q <= 1'b0;
      sync_prev_q   <= 1'b0;
    end else begin
      sync_meta_q   <= sync_event_pin;
      sync_stable_q <= sync_meta_q;
      sync_prev_q   <= sync_stable_q;
    end
  end

  // One-cycle resync request on a rising sync edge while resync is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_resync_q <= 1'b0;
    end else begin
      channel_resync_q <= sync_stable_q && !sync_prev_q && resync_enable;
    end
  end

  assign channel_resync = channel_resync_q;

  // Control fields straight from the register flops
  assign post_divider_select          = regs_q[SLOT_CTRL_A][POST_SEL_MSB:POST_SEL_LSB];
  assign resync_enable                = regs_q[SLOT_CTRL_A][RESYNC_BIT];
  assign synth_power_down             = regs_q[SLOT_CTRL_A][PDN_BIT];
  assign secondary_ref_doubler_enable = regs_q[SLOT_CTRL_B][DOUBLER_BIT];
  assign charge_pump_gain             = regs_q[SLOT_CTRL_B][CP_MSB:0];

  // Divider words assembled from their byte registers
  assign integer_feedback_divider = {regs_q[SLOT_DIV_HIGH][DIV_HI_MSB:0],
                                     regs_q[SLOT_DIV_LOW]};
  assign fractional_numerator     = {regs_q[SLOT_NUM_TOP][TOP6_MSB:0],
                                     regs_q[SLOT_NUM_MID],
                                     regs_q[SLOT_NUM_BOTTOM]};
  assign fractional_denominator_top = regs_q[SLOT_DEN_TOP][TOP6_MSB:0];

  // Feed the decoder; its outputs are registered one cycle behind the fields
  assign cfg_bus.post_sel = post_divider_select;
  assign cfg_bus.int_div  = integer_feedback_divider;
  assign cfg_bus.cp_gain  = charge_pump_gain;

  synth_cfg_decode u_decode (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg_bus.decode)
  );

  // Decoded ratios and current
  assign post_divide_ratio    = cfg_bus.post_ratio;
  assign integer_divide_ratio = cfg_bus.int_ratio;
  assign charge_pump_current  = cfg_bus.cp_current;

endmodule

// File: sim/synth2_cfg_checker.sv
`timescale 1ns/100ps
module synth2_cfg_checker
  import synth2_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Bus answer
  input wire logic              pready,
  input wire logic [APB_DW-1:0] prdata,
  // Sync path
  input wire logic              sync_event_pin,
  input wire logic              channel_resync,
  input wire logic              resync_enable,
  // Power and calibration
  input wire logic              synth_power_down,
  input wire logic              synth_enable,
  input wire logic              cal_reset,
  input wire logic              cal_busy,
  input wire logic              cal_done,
  // Loop settings
  input wire logic [3:0]        charge_pump_gain,
  input wire logic [6:0]        charge_pump_current,
  input wire logic [2:0]        post_divider_select,
  input wire logic [3:0]        post_divide_ratio,
  input wire logic [11:0]       integer_feedback_divider,
  input wire logic [11:0]       integer_divide_ratio
);
  // Two spare edges on boot, since release lands between edges
  localparam int CAL_LIM = CAL_CYCLES + 2;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Calibration steps: running, then finished
  sequence s_cal_run;
    synth_enable && cal_busy && !cal_reset && !cal_done;
  endsequence
  sequence s_cal_end;
    cal_done && !cal_busy;
  endsequence

  property p_post_ratio;
    post_divide_ratio == (($past(post_divider_select) < 3'h2) ? 4'h2 :
                          ({1'b0, $past(post_divider_select)} + 4'h1));
  endproperty
  property p_int_ratio;
    integer_divide_ratio == (($past(integer_feedback_divider) < 12'h002) ? 12'h001 :
                             $past(integer_feedback_divider));
  endproperty
  property p_cp_gain;
    (charge_pump_gain == 4'h4 |=> charge_pump_current == 7'h40) and
    (charge_pump_gain == 4'h8 |=> charge_pump_current == 7'h1c);
  endproperty
  property p_boot;
    $rose(presetn) |-> synth_enable && !cal_reset ##[1:CAL_LIM] s_cal_end;
  endproperty
  property p_pdn;
    synth_power_down |=> !synth_enable && cal_reset && !cal_busy && !cal_done;
  endproperty
  property p_restart;
    $fell(synth_power_down) |=> s_cal_run ##CAL_CYCLES s_cal_end;
  endproperty
  property p_resync_on;
    $rose(sync_event_pin) && resync_enable |-> ##3 channel_resync ##1 !channel_resync;
  endproperty
  property p_resync_off;
    $rose(sync_event_pin) && !resync_enable |-> ##1 !channel_resync [*5];
  endproperty
  property p_read_zero;
    pready && prdata[31:8] == 24'h000000;
  endproperty

  a_post_ratio: assert property (p_post_ratio) else $error("post ratio wrong");
  a_int_ratio: assert property (p_int_ratio) else $error("int ratio wrong");
  a_cp_gain: assert property (p_cp_gain) else $error("pump current wrong");
  a_boot: assert property (p_boot) else $error("boot calibration wrong");
  a_pdn: assert property (p_pdn) else $error("power down not held");
  a_restart: assert property (p_restart) else $error("restart wrong");
  a_resync_on: assert property (p_resync_on) else $error("resync pulse missing");
  a_resync_off: assert property (p_resync_off) else $error("resync not blocked");
  a_read_zero: assert property (p_read_zero) else $error("upper read bits set");
endmodule

bind second_synth_config_regs synth2_cfg_checker #(.CAL_CYCLES(CAL_CYCLES)) chk (
  .pclk, .presetn, .pready, .prdata, .sync_event_pin, .channel_resync, .resync_enable,
  .synth_power_down, .synth_enable, .cal_reset, .cal_busy, .cal_done, .charge_pump_gain,
  .charge_pump_current, .post_divider_select, .post_divide_ratio,
  .integer_feedback_divider, .integer_divide_ratio
);

// File: sim/second_synth_config_regs_test.sv
`timescale 1ns/100ps
module second_synth_config_regs_test
  import synth2_pkg::*;
();
  localparam int CAL = 4;
  localparam logic [11:0] RA [8] = '{{IDX_CTRL_A, 2'b00}, {IDX_CTRL_B, 2'b00},
    {IDX_DIV_HIGH, 2'b00}, {IDX_DIV_LOW, 2'b00}, {IDX_NUM_TOP, 2'b00},
    {IDX_NUM_MID, 2'b00}, {IDX_NUM_BOTTOM, 2'b00}, {IDX_DEN_TOP, 2'b00}};
  localparam logic [7:0] RSTV [8] = '{8'h1e, 8'h18, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [8] = '{8'h1f, 8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h3f};
  localparam logic [6:0] CPT [16] = '{7'h00, 7'h04, 7'h08, 7'h10, 7'h40, 7'h0c, 7'h14, 7'h18,
    7'h1c, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        sync_event_pin = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, channel_resync, synth_enable, cal_reset, cal_busy, cal_done;
  logic        secondary_ref_doubler_enable, resync_enable, synth_power_down;
  logic [3:0]  charge_pump_gain, post_divide_ratio;
  logic [6:0]  charge_pump_current;
  logic [2:0]  post_divider_select;
  logic [11:0] integer_feedback_divider, integer_divide_ratio;
  logic [21:0] fractional_numerator;
  logic [5:0]  fractional_denominator_top;
  logic [32:0] exp_q [$];
  int          bad_count = 0;
  int          cmp_count = 0;
  int          pulses = 0;
  int          seed = 27;

  second_synth_config_regs #(.CAL_CYCLES(CAL)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_event_pin(sync_event_pin), .channel_resync(channel_resync),
    .synth_enable(synth_enable), .cal_reset(cal_reset), .cal_busy(cal_busy),
    .cal_done(cal_done), .secondary_ref_doubler_enable(secondary_ref_doubler_enable),
    .charge_pump_gain(charge_pump_gain), .charge_pump_current(charge_pump_current),
    .post_divider_select(post_divider_select), .post_divide_ratio(post_divide_ratio),
    .resync_enable(resync_enable), .synth_power_down(synth_power_down),
    .integer_feedback_divider(integer_feedback_divider),
    .integer_divide_ratio(integer_divide_ratio), .fractional_numerator(fractional_numerator),
    .fractional_denominator_top(fractional_denominator_top));

  // Free-running bus clock
  always #50 pclk = ~pclk;

  // One bus transfer; upper data bits are random since the slave must ignore them
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= ({$random(seed)} & 32'hffffff00) | {24'h0, d};
    pstrb   <= s;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    apb(RA[i], 1'b1, d, 4'hf);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 8'h00, 4'h0);
  endtask
  // Step past an edge so its updates have landed before looking
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic sync_evt;
    @(posedge pclk);
    sync_event_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    sync_event_pin <= 1'b0;
    tick(6);
  endtask
  task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_out(input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wrap_up;
    // A read that never completed leaves its note behind
    if (exp_q.size() != 0) begin
      bad_count++;
    end
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read monitor: oldest note against error flag and data
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      chk_rd(exp_q.pop_front(), {pslverr, prdata});
    end
  end
  // Count resync pulses
  always @(posedge pclk) begin
    if (channel_resync === 1'b1) begin
      pulses++;
    end
  end
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end

  initial begin
    logic [7:0] v [8];
    int         p0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    tick(CAL + 2);
    for (int i = 0; i < 8; i++) rd(RA[i], {25'h0, RSTV[i]});
    rd({IDX_STATUS, 2'b00}, 33'h5);
    for (int i = 0; i < 8; i++) begin
      wr(i, 8'hff);
      rd(RA[i], {25'h0, MSK[i]});
    end
    for (int i = 0; i < 8; i++) begin
      v[i] = 8'($random(seed));
      wr(i, v[i]);
      rd(RA[i], {25'h0, v[i] & MSK[i]});
    end
    tick(1);
    chk_out({integer_feedback_divider, fractional_numerator, 6'h0},
            {v[2][3:0], v[3], v[4][5:0], v[5], v[6], 6'h0});
    // Doubler sits above the gain field, so it leads in the packed word
    chk_out({fractional_denominator_top, secondary_ref_doubler_enable, charge_pump_gain,
             post_divider_select, resync_enable, synth_power_down, 24'h0},
            {v[7][5:0], v[1][4:0], v[0][4:0], 24'h0});
    // Every select and gain code, divider codes around the floor
    wr(2, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(0, {3'h0, i[2:0], 2'b10});
      wr(1, {4'h1, i[3:0]});
      wr(3, i[7:0]);
      tick(1);
      chk_out({post_divide_ratio, charge_pump_current, integer_divide_ratio, 17'h0},
              {(i[2:0] < 3'h2) ? 4'h2 : ({1'b0, i[2:0]} + 4'h1), CPT[i],
               (i < 2) ? 12'h001 : 12'(i), 17'h0});
    end
    wr(2, 8'h0f);
    wr(3, 8'hff);
    tick(1);
    chk_out({integer_divide_ratio, 28'h0}, {12'hfff, 28'h0});
    // Low byte lane off, unmapped and unaligned places
    apb(RA[3], 1'b1, 8'h12, 4'he);
    rd(RA[3], 33'h0ff);
    rd(12'h200, {1'b1, 32'h0});
    rd(RA[0] + 12'h001, {1'b1, 32'h0});
    // Power down, then let calibration restart by itself
    wr(0, 8'h1f);
    tick(1);
    chk_out({synth_enable, cal_reset, cal_busy, cal_done, 36'h0}, {4'b0100, 36'h0});
    wr(0, 8'h1e);
    tick(1);
    chk_out({synth_enable, cal_reset, cal_busy, cal_done, 36'h0}, {4'b1010, 36'h0});
    tick(CAL + 1);
    rd({IDX_STATUS, 2'b00}, 33'h5);
    // Sync events with resync on, then off
    p0 = pulses;
    sync_evt();
    chk_out(40'(pulses - p0), 40'h1);
    wr(0, 8'h1c);
    p0 = pulses;
    sync_evt();
    chk_out(40'(pulses - p0), 40'h0);
    tick(2);
    wrap_up();
  end
endmodule
